//--- core/rgc_defs.svh
// Register offsets, field positions, reset values and timing counts of the receiver gain bank
`ifndef RGC_DEFS_SVH
`define RGC_DEFS_SVH
`define RGC_OFS_DEMOD_AGC 8'h0c
`define RGC_OFS_FIRST_GAIN 8'h0d
`define RGC_OFS_LATER_GAIN 8'h0e
`define RGC_RST_DEMOD_AGC 8'h2c
`define RGC_RST_FIRST_GAIN 8'hd8
`define RGC_RST_LATER_GAIN 8'h00
`define RGC_BIT_DEMOD_MODE 7
`define RGC_BIT_AM_DET 6
`define RGC_BIT_SQ_DYN 5
`define RGC_BIT_SQ_RATIO 4
`define RGC_BIT_AGC_EN 3
`define RGC_BIT_AGC_SPAN 2
`define RGC_BIT_AGC_ALG 1
`define RGC_BIT_AGC_RATIO 0
`define RGC_POS_AM_FIRST 5
`define RGC_POS_PM_FIRST 2
`define RGC_BIT_LF_SEL 1
`define RGC_BIT_LF_SPLIT 0
`define RGC_POS_AM_LATER 4
`define RGC_POS_PM_LATER 0
`define RGC_LATER_MAX 4'ha
`define RGC_CLK_NS 40
`define RGC_SQ_DELAY_NS 18880
// Least time rounds up to whole cycles, both figures in ns
`define RGC_SQ_DELAY_CYC ((`RGC_SQ_DELAY_NS + `RGC_CLK_NS - 1) / `RGC_CLK_NS)
`define RGC_AGC_PULSES 8
`endif

//--- core/rgc_pkg.sv
// Types of the receiver gain configuration bank
package rgc_pkg;
  typedef struct packed {
    logic iq_demod;
    logic am_mixer;
    logic squelch_ratio_hi;
    logic agc_enable;
    logic agc_reset_alg;
    logic agc_ratio_six;
    logic [2:0] am_first_stage_gain;
    logic [2:0] pm_first_stage_gain;
    logic lf_input_select;
    logic lf_split_select;
  } rgc_cfg_type;
  typedef struct packed {
    logic [3:0] am_later_stage_gain;
    logic [3:0] pm_later_stage_gain;
  } rgc_later_type;
endpackage : rgc_pkg

//--- core/rgc_squelch_timer.sv
// Dynamic squelch window timer: opens after end of transmit, closes on mask timeout
`timescale 1ns/100ps
module rgc_squelch_timer #(
  parameter int DELAY_CYC = 1
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic enable, // Dynamic squelch enabled
  input wire logic tx_end, // One-cycle pulse at end of transmit
  input wire logic mask_timeout, // Mask receive timer hit squelch timeout
  output logic squelch_on // Squelch active
);
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_WAIT = 2'b01,
    SQ_ON = 2'b10
  } rgc_sq_state_type;
  rgc_sq_state_type state_ff;
  logic [15:0] cnt_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      state_ff <= SQ_IDLE;
      cnt_ff <= 16'h0000;
    end else begin
      unique case (state_ff)
        SQ_IDLE: begin
          if (tx_end) begin
            state_ff <= SQ_WAIT;
            cnt_ff <= 16'h0001;
          end
        end
        SQ_WAIT: begin
          if (cnt_ff >= 16'(DELAY_CYC)) begin
            state_ff <= SQ_ON; // RULE2
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        SQ_ON: begin
          if (mask_timeout) begin
            state_ff <= SQ_IDLE; // RULE2
          end
        end
        default: state_ff <= SQ_IDLE;
      endcase
    end
  end
  assign squelch_on = (state_ff == SQ_ON);
  property p_sq_delay;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(squelch_on) |-> $past(state_ff) == SQ_WAIT && cnt_ff == 16'(DELAY_CYC);
  endproperty
  a_sq_delay: assert property (p_sq_delay) else $error("squelch came on too early"); // RULE2
  property p_sq_off;
    @(posedge core_clk) disable iff (!rst_n)
    (squelch_on && mask_timeout) |=> !squelch_on;
  endproperty
  a_sq_off: assert property (p_sq_off) else $error("squelch not released on timeout"); // RULE2
  property p_sq_disabled;
    @(posedge core_clk) disable iff (!rst_n)
    !enable |=> !squelch_on;
  endproperty
  a_sq_disabled: assert property (p_sq_disabled) else $error("squelch on while disabled"); // RULE2
  c_sq_on: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(squelch_on));
endmodule : rgc_squelch_timer

//--- core/rgc_bank.sv
// Receiver demodulator, squelch and gain configuration register bank
// Function
// RULE1: Bit 7 picks AM/PM or I/Q; bit 6 picks peak or mixer detector.
// RULE2: Dynamic squelch starts 18.88 us after transmit, ends on mask timeout.
// RULE3: Squelch ratio bit picks trigger at threshold or six-thirds of it.
// RULE4: Gain control enable bit, span bit picks eight pulses or whole receive.
// RULE5: Algorithm bit picks preset-based or reset-based gain control.
// RULE6: Ratio bit picks gain trigger at three or six times minimum.
// RULE7: AM first-stage gain field bits 7:5, resets to 6.
// RULE8: PM first-stage gain field bits 4:2, resets to 6, same codes.
// RULE9: Bit 1 routes receiver input as HF or LF.
// RULE10: Bit 0 picks differential LF or split inputs to AM and PM.
// RULE11: Later-stage gain register holds AM and PM 4-bit codes 0 to A.
// RULE12: Later-stage gain applies only on the reset-receive-gain command.
// RULE13: Software never writes codes B to F into later-stage fields.
`timescale 1ns/100ps
`include "rgc_defs.svh"
module rgc_bank #(
  parameter int AGC_PULSES = `RGC_AGC_PULSES
) (
  input wire logic core_clk, // System clock, 25 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic reg_wr, // Register write strobe from host port
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data of addressed register
  input wire logic reset_rx_gain, // Reset-receive-gain command pulse
  input wire logic tx_end, // End of transmit pulse
  input wire logic mask_timeout, // Mask timer reached squelch timeout
  input wire logic rx_active, // Receive period in progress
  input wire logic subcarrier_pulse, // One pulse per subcarrier pulse
  output rgc_pkg::rgc_cfg_type cfg, // Decoded configuration to analogue chain
  output rgc_pkg::rgc_later_type later_gain, // Applied later-stage gain codes
  output logic squelch_on, // Dynamic squelch active
  output logic agc_active // Gain control currently allowed to act
);
  logic [7:0] demod_agc_ff;
  logic [7:0] first_gain_ff;
  logic [7:0] later_gain_ff;
  rgc_pkg::rgc_later_type applied_ff;
  logic [3:0] pulse_cnt_ff;
  logic [3:0] nxt_pulse_cnt;

  function automatic logic [3:0] clip_code(input logic [3:0] code);
    clip_code = (code > `RGC_LATER_MAX) ? `RGC_LATER_MAX : code;
  endfunction : clip_code

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      demod_agc_ff <= `RGC_RST_DEMOD_AGC;
    end else if (reg_wr && reg_addr == `RGC_OFS_DEMOD_AGC) begin
      demod_agc_ff <= reg_wdata; // RULE1
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      first_gain_ff <= `RGC_RST_FIRST_GAIN; // RULE7 RULE8
    end else if (reg_wr && reg_addr == `RGC_OFS_FIRST_GAIN) begin
      first_gain_ff <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      later_gain_ff <= `RGC_RST_LATER_GAIN;
    end else if (reg_wr && reg_addr == `RGC_OFS_LATER_GAIN) begin
      later_gain_ff <= reg_wdata; // RULE11
    end
  end

  // Stored value reaches gain, squelch and strength logic only on command
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      applied_ff <= '0;
    end else if (reset_rx_gain) begin
      applied_ff.am_later_stage_gain <= clip_code(later_gain_ff[`RGC_POS_AM_LATER +: 4]); // RULE12 RULE13
      applied_ff.pm_later_stage_gain <= clip_code(later_gain_ff[`RGC_POS_PM_LATER +: 4]); // RULE12 RULE13
    end
  end
  assign later_gain = applied_ff;

  always_comb begin
    unique case (reg_addr)
      `RGC_OFS_DEMOD_AGC: reg_rdata = demod_agc_ff;
      `RGC_OFS_FIRST_GAIN: reg_rdata = first_gain_ff;
      `RGC_OFS_LATER_GAIN: reg_rdata = later_gain_ff;
      default: reg_rdata = 8'h00;
    endcase
  end

  always_comb begin
    cfg.iq_demod = demod_agc_ff[`RGC_BIT_DEMOD_MODE]; // RULE1
    cfg.am_mixer = demod_agc_ff[`RGC_BIT_AM_DET]; // RULE1
    cfg.squelch_ratio_hi = demod_agc_ff[`RGC_BIT_SQ_RATIO]; // RULE3
    cfg.agc_enable = demod_agc_ff[`RGC_BIT_AGC_EN]; // RULE4
    cfg.agc_reset_alg = demod_agc_ff[`RGC_BIT_AGC_ALG]; // RULE5
    cfg.agc_ratio_six = demod_agc_ff[`RGC_BIT_AGC_RATIO]; // RULE6
    cfg.am_first_stage_gain = first_gain_ff[`RGC_POS_AM_FIRST +: 3]; // RULE7
    cfg.pm_first_stage_gain = first_gain_ff[`RGC_POS_PM_FIRST +: 3]; // RULE8
    cfg.lf_input_select = first_gain_ff[`RGC_BIT_LF_SEL]; // RULE9
    cfg.lf_split_select = first_gain_ff[`RGC_BIT_LF_SPLIT]; // RULE10
  end

  // Counts subcarrier pulses within a receive period for the short span
  always_comb begin
    nxt_pulse_cnt = pulse_cnt_ff;
    if (!rx_active) begin
      nxt_pulse_cnt = 4'h0;
    end else if (subcarrier_pulse && pulse_cnt_ff < 4'(AGC_PULSES)) begin
      nxt_pulse_cnt = pulse_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pulse_cnt_ff <= 4'h0;
    end else begin
      pulse_cnt_ff <= nxt_pulse_cnt;
    end
  end

  assign agc_active = demod_agc_ff[`RGC_BIT_AGC_EN] && rx_active &&
                      (demod_agc_ff[`RGC_BIT_AGC_SPAN] || pulse_cnt_ff < 4'(AGC_PULSES)); // RULE4

  rgc_squelch_timer #(
    .DELAY_CYC(`RGC_SQ_DELAY_CYC)
  ) u_squelch (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(demod_agc_ff[`RGC_BIT_SQ_DYN]), // RULE2
    .tx_end(tx_end),
    .mask_timeout(mask_timeout),
    .squelch_on(squelch_on)
  );

  property p_later_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !reset_rx_gain |=> $stable(applied_ff);
  endproperty
  a_later_hold: assert property (p_later_hold) else $error("later gain changed without command"); // RULE12
  property p_later_load;
    @(posedge core_clk) disable iff (!rst_n)
    (reset_rx_gain && later_gain_ff[7:4] <= `RGC_LATER_MAX) |=>
      applied_ff.am_later_stage_gain == $past(later_gain_ff[7:4]);
  endproperty
  a_later_load: assert property (p_later_load) else $error("AM later gain not loaded"); // RULE12
  property p_later_range;
    @(posedge core_clk) disable iff (!rst_n)
    applied_ff.pm_later_stage_gain <= `RGC_LATER_MAX && applied_ff.am_later_stage_gain <= `RGC_LATER_MAX;
  endproperty
  a_later_range: assert property (p_later_range) else $error("applied later gain out of range"); // RULE11
  property p_agc_off;
    @(posedge core_clk) disable iff (!rst_n)
    !cfg.agc_enable |-> !agc_active;
  endproperty
  a_agc_off: assert property (p_agc_off) else $error("gain control active while disabled"); // RULE4
  property p_agc_short;
    @(posedge core_clk) disable iff (!rst_n)
    (!demod_agc_ff[`RGC_BIT_AGC_SPAN] && pulse_cnt_ff == 4'(AGC_PULSES)) |-> !agc_active;
  endproperty
  a_agc_short: assert property (p_agc_short) else $error("gain control beyond eight pulses"); // RULE4
  property p_first_field;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `RGC_OFS_FIRST_GAIN) |=> cfg.am_first_stage_gain == $past(reg_wdata[7:5]) &&
      cfg.pm_first_stage_gain == $past(reg_wdata[4:2]) && cfg.lf_input_select == $past(reg_wdata[1]);
  endproperty
  a_first_field: assert property (p_first_field) else $error("first-stage fields misplaced"); // RULE7
  property p_demod_field;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `RGC_OFS_DEMOD_AGC) |=> cfg.iq_demod == $past(reg_wdata[7]) &&
      cfg.am_mixer == $past(reg_wdata[6]) && cfg.agc_ratio_six == $past(reg_wdata[0]);
  endproperty
  a_demod_field: assert property (p_demod_field) else $error("demodulator fields misplaced"); // RULE1
  property p_split_field;
    @(posedge core_clk) disable iff (!rst_n)
    cfg.lf_split_select == first_gain_ff[0] && cfg.squelch_ratio_hi == demod_agc_ff[4] &&
      cfg.agc_reset_alg == demod_agc_ff[1];
  endproperty
  a_split_field: assert property (p_split_field) else $error("mode bits misrouted"); // RULE10
  property p_later_load_pm;
    @(posedge core_clk) disable iff (!rst_n)
    (reset_rx_gain && later_gain_ff[3:0] <= `RGC_LATER_MAX) |=> applied_ff.pm_later_stage_gain == $past(later_gain_ff[3:0]);
  endproperty
  a_later_load_pm: assert property (p_later_load_pm) else $error("PM later gain not loaded"); // RULE12
  property p_later_clip;
    @(posedge core_clk) disable iff (!rst_n)
    (reset_rx_gain && later_gain_ff[7:4] > `RGC_LATER_MAX) |=> applied_ff.am_later_stage_gain == `RGC_LATER_MAX;
  endproperty
  a_later_clip: assert property (p_later_clip) else $error("unused later gain code not clipped"); // RULE11
  property p_later_store;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `RGC_OFS_LATER_GAIN) |=> later_gain_ff == $past(reg_wdata);
  endproperty
  a_later_store: assert property (p_later_store) else $error("later gain register not written"); // RULE11
  property p_ratio_field;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `RGC_OFS_DEMOD_AGC) |=> cfg.squelch_ratio_hi == $past(reg_wdata[4]) &&
      cfg.agc_reset_alg == $past(reg_wdata[1]);
  endproperty
  a_ratio_field: assert property (p_ratio_field) else $error("ratio or algorithm bit misplaced"); // RULE3
  property p_agc_en_field;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `RGC_OFS_DEMOD_AGC) |=> cfg.agc_enable == $past(reg_wdata[3]);
  endproperty
  a_agc_en_field: assert property (p_agc_en_field) else $error("gain control enable misplaced"); // RULE4
  property p_pulse_clear;
    @(posedge core_clk) disable iff (!rst_n)
    !rx_active |=> pulse_cnt_ff == 4'h0;
  endproperty
  a_pulse_clear: assert property (p_pulse_clear) else $error("pulse count kept outside receive"); // RULE4
  property p_pulse_cap;
    @(posedge core_clk) disable iff (!rst_n)
    pulse_cnt_ff <= 4'(AGC_PULSES);
  endproperty
  a_pulse_cap: assert property (p_pulse_cap) else $error("pulse count beyond limit"); // RULE4
  property p_agc_full;
    @(posedge core_clk) disable iff (!rst_n)
    (cfg.agc_enable && rx_active && demod_agc_ff[2]) |-> agc_active;
  endproperty
  a_agc_full: assert property (p_agc_full) else $error("gain control idle in whole-period span"); // RULE4
  property p_lf_split_wr;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `RGC_OFS_FIRST_GAIN) |=> cfg.lf_split_select == $past(reg_wdata[0]);
  endproperty
  a_lf_split_wr: assert property (p_lf_split_wr) else $error("split select misplaced"); // RULE10
  c_load: cover property (@(posedge core_clk) disable iff (!rst_n) reset_rx_gain ##1 applied_ff != '0);
  c_short_span: cover property (@(posedge core_clk) disable iff (!rst_n)
    !demod_agc_ff[2] && pulse_cnt_ff == 4'(AGC_PULSES));
  c_iq: cover property (@(posedge core_clk) disable iff (!rst_n) cfg.iq_demod && cfg.am_mixer);
endmodule : rgc_bank

//--- verif/test_rgc_bank.sv
// Self-checking testbench of the receiver gain configuration bank
`timescale 1ns/100ps
module test_rgc_bank;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rgc_row_type;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reset_rx_gain = 1'b0;
  logic tx_end = 1'b0;
  logic mask_timeout = 1'b0;
  logic rx_active = 1'b0;
  logic subcarrier_pulse = 1'b0;
  rgc_pkg::rgc_cfg_type cfg;
  rgc_pkg::rgc_later_type later_gain;
  logic squelch_on;
  logic agc_active;
  int fails = 0;
  int n_compared = 0;
  logic [7:0] shadow [3];
  rgc_row_type rows [10];
  rgc_bank rgc_bank_inst (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reset_rx_gain(reset_rx_gain), .tx_end(tx_end), .mask_timeout(mask_timeout),
    .rx_active(rx_active), .subcarrier_pulse(subcarrier_pulse), .cfg(cfg), .later_gain(later_gain),
    .squelch_on(squelch_on), .agc_active(agc_active)
  );
  always #20 core_clk = ~core_clk;
  function automatic logic [15:0] exp_cfg(input logic [7:0] a, input logic [7:0] b);
    return {2'h0, a[7], a[6], a[4], a[3], a[1], a[0], b};
  endfunction : exp_cfg
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
  initial begin
    rows = '{'{8'h0c, 8'hc0}, '{8'h0c, 8'h5b}, '{8'h0c, 8'h02}, '{8'h0d, 8'h24}, '{8'h0d, 8'hfc},
             '{8'h0d, 8'h03}, '{8'h0e, 8'h35}, '{8'h0f, 8'hff}, '{8'h0b, 8'h77}, '{8'h0c, 8'h11}};
    shadow = '{8'h2c, 8'hd8, 8'h00};
    step(16);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      reg_addr = 8'h0c + 8'(i);
      step(1);
      chk(16'(reg_rdata), 16'(shadow[i]), "reset value");
    end
    chk(16'(cfg), exp_cfg(8'h2c, 8'hd8), "reset cfg");
    chk(16'(later_gain), 16'h0000, "reset later gain");
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].data);
      if (rows[i].addr >= 8'h0c && rows[i].addr <= 8'h0e) begin
        shadow[rows[i].addr - 8'h0c] = rows[i].data;
      end
      chk(16'(reg_rdata), (rows[i].addr >= 8'h0c && rows[i].addr <= 8'h0e) ? 16'(rows[i].data) : 16'h0000,
          "readback");
      chk(16'(cfg), exp_cfg(shadow[0], shadow[1]), "cfg fields");
    end
    chk(16'(later_gain), 16'h0000, "later gain before command");
    $display("register table test done");
    reset_rx_gain = 1'b1;
    step(1);
    reset_rx_gain = 1'b0;
    chk(16'(later_gain), 16'h0035, "later gain applied");
    wr(8'h0e, 8'ha0);
    chk(16'(later_gain), 16'h0035, "later gain held");
    reset_rx_gain = 1'b1;
    step(1);
    reset_rx_gain = 1'b0;
    chk(16'(later_gain), 16'h00a0, "later gain top code");
    $display("later gain test done");
    wr(8'h0c, 8'h08);
    rx_active = 1'b1;
    step(1);
    for (int i = 0; i < 8; i++) begin
      chk(16'(agc_active), 16'h0001, "gain control in first pulses");
      subcarrier_pulse = 1'b1;
      step(1);
      subcarrier_pulse = 1'b0;
      step(1);
    end
    chk(16'(agc_active), 16'h0000, "gain control after eight pulses");
    wr(8'h0c, 8'h0c);
    chk(16'(agc_active), 16'h0001, "gain control whole period");
    wr(8'h0c, 8'h04);
    chk(16'(agc_active), 16'h0000, "gain control disabled");
    rx_active = 1'b0;
    $display("gain control test done");
    wr(8'h0c, 8'h20);
    tx_end = 1'b1;
    step(1);
    tx_end = 1'b0;
    // 18.88 us at 40 ns is 472 cycles after the edge that took tx_end
    step(471);
    chk(16'(squelch_on), 16'h0000, "squelch too early");
    step(1);
    chk(16'(squelch_on), 16'h0001, "squelch after delay");
    mask_timeout = 1'b1;
    step(1);
    mask_timeout = 1'b0;
    step(1);
    chk(16'(squelch_on), 16'h0000, "squelch ended by mask timeout");
    wr(8'h0c, 8'h00);
    tx_end = 1'b1;
    step(1);
    tx_end = 1'b0;
    step(480);
    chk(16'(squelch_on), 16'h0000, "squelch disabled");
    $display("squelch test done");
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    reg_addr = 8'h0d;
    step(1);
    chk(16'(reg_rdata), 16'h00d8, "second reset value");
    chk(16'(cfg), exp_cfg(8'h2c, 8'hd8), "second reset cfg");
    chk(16'(squelch_on), 16'h0000, "second reset squelch");
    chk(16'(later_gain), 16'h0000, "second reset later gain");
    $display("second reset test done");
    wrap_up();
  end
endmodule : test_rgc_bank
